// *** src/ptmr_pkg.sv ***
// Purpose: constants for the paired 16/32-bit timer block
// Assumes: AHB-Lite word registers, 40 MHz hclk
// Notes: offsets below are byte addresses of 32-bit words
//
// Behaviour
// R1 - Combined pair: even timer is low word, odd timer high word.
// R2 - Wide mode ignores odd control; odd interrupt flag reports pair.
// R3 - Pair-select bit 3 of even control joins timers into 32 bits.
// R4 - Run bit 15 starts/stops; even run bit controls the pair.
// R5 - Idle-halt bit 13 stops the timer while device is idle.
// R6 - Gate bit 6 enables gated accumulation only with internal clock.
// R7 - Prescale bits 5-4 divide by 1, 8, 64 or 256.
// R8 - Even clock-source bit 1 picks external pin rising edges.
// R9 - Odd timer alone counts its own pin edges when selected.
// R10 - Count registers hold live count, odd high word, even low.
// R11 - Wide period: odd period high, even low; interrupt on match.
// R12 - Only the odd timer drives the converter trigger.
// R13 - Timers are synchronous only; no asynchronous counting.
// R14 - Software sets wide mode, setup, periods, then run bit last.
// R15 - Software sets single mode, setup, period, then run bit last.
// R16 - Unused control bits ignore writes and read zero.
// R17 - On period match set flag and clear count next tick.
// R18 - Gated mode counts while gate high; irq on gate fall.
// R19 - All control bits reset to zero.
package ptmr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_EVEN_CON = 8'h00;
    localparam logic [7:0] OFS_ODD_CON = 8'h04;
    localparam logic [7:0] OFS_LOW_CNT = 8'h08;
    localparam logic [7:0] OFS_HIGH_CNT = 8'h0C;
    localparam logic [7:0] OFS_LOW_PER = 8'h10;
    localparam logic [7:0] OFS_HIGH_PER = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h20;
    // Control field positions
    localparam int BIT_RUN = 15;
    localparam int BIT_IDLE = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_WIDE = 3;
    localparam int BIT_CSRC = 1;
    // Writable masks (even has pair select, odd does not)
    localparam logic [15:0] EVEN_MASK = 16'hA07A;
    localparam logic [15:0] ODD_MASK = 16'hA072;
    localparam logic [15:0] CON_RESET = 16'h0000;
    localparam logic [15:0] PER_RESET = 16'hFFFF;
    // Prescale codes and ratios
    localparam logic [1:0] PS_1 = 2'h0;
    localparam logic [1:0] PS_8 = 2'h1;
    localparam logic [1:0] PS_64 = 2'h2;
    localparam logic [7:0] DIV_8 = 8'h07;
    localparam logic [7:0] DIV_64 = 8'h3F;
    localparam logic [7:0] DIV_256 = 8'hFF;
    // Interrupt status bits
    localparam int IRQ_EVEN = 0;
    localparam int IRQ_ODD = 1;
    localparam int IRQ_W = 2;
endpackage

// *** src/ptmr_tick.sv ***
`timescale 1ns/1ps
// Purpose: clock select, gate and prescaler for one timer
// Assumes: pins synchronous to hclk
// Notes: emits a one-cycle count tick and a gate-fall pulse
module ptmr_tick (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Settings
    input wire logic run,
    input wire logic idle_stop,
    input wire logic gate_en,
    input wire logic [1:0] prescale_sel,
    input wire logic clock_sel,
    // Pins
    input wire logic ext_pin,
    input wire logic gate_pin,
    // Results
    output logic tick,
    output logic gate_fall
);
    logic pin_ff;
    logic gate_ff;
    logic [7:0] div_ff;
    logic [7:0] nxt_div;
    wire ext_rise = ext_pin & ~pin_ff;
    wire gated = gate_en & ~clock_sel;
    // Gate ignored when external clock chosen
    wire raw = clock_sel ? ext_rise : (~gated | gate_pin); // R6 R8 R9 R18
    wire active = run & ~idle_stop; // R4 R5
    wire [7:0] limit = (prescale_sel == ptmr_pkg::PS_1) ? 8'h00 :
                       (prescale_sel == ptmr_pkg::PS_8) ? ptmr_pkg::DIV_8 :
                       (prescale_sel == ptmr_pkg::PS_64) ?
                       ptmr_pkg::DIV_64 : ptmr_pkg::DIV_256; // R7
    wire wrap = active & raw & (div_ff >= limit);
    assign nxt_div = !active ? 8'h00 : !raw ? div_ff :
                     wrap ? 8'h00 : div_ff + 8'h01;
    assign tick = wrap; // R13
    assign gate_fall = active & gated & gate_ff & ~gate_pin; // R18
    // Edge history and prescale count; stopping clears the prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_ff <= 1'b0;
            gate_ff <= 1'b0;
            div_ff <= 8'h00;
        end else begin
            pin_ff <= ext_pin;
            gate_ff <= gate_pin;
            div_ff <= nxt_div;
        end
    end
endmodule

// *** src/ptmr_top.sv ***
`timescale 1ns/1ps
// Purpose: paired 16-bit timers, joinable into one 32-bit timer
// Assumes: AHB-Lite slave, one clock, zero wait states
// Notes: idle input from power manager; pins synchronous to hclk
module ptmr_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Device state and pins
    input wire logic device_idle,
    input wire logic even_ext_clock_pin,
    input wire logic odd_ext_clock_pin,
    input wire logic even_gate_pin,
    input wire logic odd_gate_pin,
    // Events
    output logic irq,
    output logic adc_trigger
);
    // Assertions below share this clock and reset
    default clocking dcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Bus slave
    logic [15:0] even_control_reg_ff;
    logic [15:0] odd_control_reg_ff;
    logic [15:0] low_count_value_ff;
    logic [15:0] high_count_value_ff;
    logic [15:0] low_period_value_ff;
    logic [15:0] high_period_value_ff;
    logic [1:0] stat_ff;
    logic [1:0] en_ff;
    logic [7:0] wadr_ff;
    logic wr_ff;
    logic [31:0] hrdata_ff;
    logic irq_ff;
    logic adc_ff;
    logic rdy_ff;
    logic resp_ff;

    wire take = hsel & hready & htrans[1];
    wire [7:0] radr = haddr;
    wire do_wr = wr_ff;
    wire [15:0] wd = hwdata[15:0];
    wire w_econ = do_wr & (wadr_ff == ptmr_pkg::OFS_EVEN_CON);
    wire w_ocon = do_wr & (wadr_ff == ptmr_pkg::OFS_ODD_CON);
    wire w_lcnt = do_wr & (wadr_ff == ptmr_pkg::OFS_LOW_CNT);
    wire w_hcnt = do_wr & (wadr_ff == ptmr_pkg::OFS_HIGH_CNT);
    wire w_lper = do_wr & (wadr_ff == ptmr_pkg::OFS_LOW_PER);
    wire w_hper = do_wr & (wadr_ff == ptmr_pkg::OFS_HIGH_PER);
    wire w_clr = do_wr & (wadr_ff == ptmr_pkg::OFS_IRQ_CLR);
    wire w_en = do_wr & (wadr_ff == ptmr_pkg::OFS_IRQ_EN);

    // Read mux; unmapped and write-only addresses read zero
    wire [15:0] rsel =
        (radr == ptmr_pkg::OFS_EVEN_CON) ? even_control_reg_ff :
        (radr == ptmr_pkg::OFS_ODD_CON) ? odd_control_reg_ff :
        (radr == ptmr_pkg::OFS_LOW_CNT) ? low_count_value_ff :
        (radr == ptmr_pkg::OFS_HIGH_CNT) ? high_count_value_ff : // R10
        (radr == ptmr_pkg::OFS_LOW_PER) ? low_period_value_ff :
        (radr == ptmr_pkg::OFS_HIGH_PER) ? high_period_value_ff :
        (radr == ptmr_pkg::OFS_IRQ_STAT) ? {14'h0000, stat_ff} :
        (radr == ptmr_pkg::OFS_IRQ_EN) ? {14'h0000, en_ff} : 16'h0000;

    // ==========================================================
    // Mode decode
    wire wide = even_control_reg_ff[ptmr_pkg::BIT_WIDE]; // R3
    // Odd control ignored when joined
    wire [15:0] oc = wide ? even_control_reg_ff : odd_control_reg_ff; // R2
    wire ev_run = even_control_reg_ff[ptmr_pkg::BIT_RUN]; // R4
    wire ev_stop = even_control_reg_ff[ptmr_pkg::BIT_IDLE] & device_idle;
    wire od_run = odd_control_reg_ff[ptmr_pkg::BIT_RUN];
    wire od_stop = oc[ptmr_pkg::BIT_IDLE] & device_idle; // R5

    logic ev_tick;
    logic ev_gfall;
    logic od_tick;
    logic od_gfall;

    // Even timer front end also clocks the joined pair
    ptmr_tick u_even (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(ev_run),
        .idle_stop(ev_stop),
        .gate_en(even_control_reg_ff[ptmr_pkg::BIT_GATE]),
        .prescale_sel(even_control_reg_ff[ptmr_pkg::BIT_PS_HI:
                                          ptmr_pkg::BIT_PS_LO]),
        .clock_sel(even_control_reg_ff[ptmr_pkg::BIT_CSRC]), // R8
        .ext_pin(even_ext_clock_pin),
        .gate_pin(even_gate_pin),
        .tick(ev_tick),
        .gate_fall(ev_gfall)
    );

    ptmr_tick u_odd (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(od_run & ~wide),
        .idle_stop(od_stop),
        .gate_en(oc[ptmr_pkg::BIT_GATE]),
        .prescale_sel(oc[ptmr_pkg::BIT_PS_HI:ptmr_pkg::BIT_PS_LO]),
        .clock_sel(oc[ptmr_pkg::BIT_CSRC]), // R9
        .ext_pin(odd_ext_clock_pin),
        .gate_pin(odd_gate_pin),
        .tick(od_tick),
        .gate_fall(od_gfall)
    );

    // ==========================================================
    // Counters
    wire [31:0] cnt32 = {high_count_value_ff, low_count_value_ff}; // R1
    wire [31:0] per32 = {high_period_value_ff, low_period_value_ff}; // R11
    wire match32 = ev_tick & (cnt32 == per32);
    wire match_lo = ev_tick & (low_count_value_ff == low_period_value_ff);
    wire match_hi = od_tick & (high_count_value_ff == high_period_value_ff);
    // Count reaches period, then clears on the next tick
    wire [31:0] nxt32 = match32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;
    wire [15:0] nxt_lo = match_lo ? 16'h0000 : low_count_value_ff + 16'h0001;
    wire [15:0] nxt_hi = match_hi ? 16'h0000 : high_count_value_ff + 16'h0001;

    // Events: wide pair reports only on the odd flag
    wire ev_event = ~wide & (match_lo | ev_gfall); // R17 R18
    wire od_event = wide ? (match32 | ev_gfall) : (match_hi | od_gfall); // R2
    wire [1:0] evt = {od_event, ev_event};
    // Converter trigger comes from the odd timer's period event only
    wire adc_evt = wide ? match32 : match_hi; // R12

    // Control registers; unused bits masked to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            even_control_reg_ff <= ptmr_pkg::CON_RESET; // R19
            odd_control_reg_ff <= ptmr_pkg::CON_RESET;
        end else begin
            if (w_econ)
                even_control_reg_ff <= wd & ptmr_pkg::EVEN_MASK; // R16
            if (w_ocon)
                odd_control_reg_ff <= wd & ptmr_pkg::ODD_MASK; // R16
        end
    end

    // Period registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_period_value_ff <= ptmr_pkg::PER_RESET;
            high_period_value_ff <= ptmr_pkg::PER_RESET;
        end else begin
            if (w_lper)
                low_period_value_ff <= wd;
            if (w_hper)
                high_period_value_ff <= wd;
        end
    end

    // Low count: software write beats a tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_count_value_ff <= 16'h0000;
        end else if (w_lcnt) begin
            low_count_value_ff <= wd;
        end else if (ev_tick) begin
            low_count_value_ff <= wide ? nxt32[15:0] : nxt_lo; // R1 R17
        end
    end

    // High count follows the carry of the pair in wide mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_count_value_ff <= 16'h0000;
        end else if (w_hcnt) begin
            high_count_value_ff <= wd;
        end else if (wide & ev_tick) begin
            high_count_value_ff <= nxt32[31:16]; // R1
        end else if (~wide & od_tick) begin
            high_count_value_ff <= nxt_hi; // R17
        end
    end

    // ==========================================================
    // Interrupt status: a set in the same cycle beats the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_ff <= 2'h0;
            en_ff <= 2'h0;
            irq_ff <= 1'b0;
            adc_ff <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~(w_clr ? wd[1:0] : 2'h0)) | evt;
            if (w_en)
                en_ff <= wd[1:0];
            irq_ff <= |(((stat_ff & ~(w_clr ? wd[1:0] : 2'h0)) | evt)
                        & (w_en ? wd[1:0] : en_ff));
            adc_ff <= adc_evt; // R12
        end
    end

    // AHB address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wadr_ff <= 8'h00;
            wr_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
            rdy_ff <= 1'b1;
            resp_ff <= 1'b0;
        end else begin
            wadr_ff <= haddr;
            wr_ff <= take & hwrite;
            rdy_ff <= 1'b1; // Zero wait states
            resp_ff <= 1'b0;
            if (take & ~hwrite)
                hrdata_ff <= {16'h0000, rsel};
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = rdy_ff;
    assign hresp = resp_ff;
    assign irq = irq_ff;
    assign adc_trigger = adc_ff;

    // ==========================================================
    // Checks
    sequence s_wide_match;
        wide && ev_tick && cnt32 == per32;
    endsequence

    chk_wide_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_wide_match and (!w_lcnt && !w_hcnt)) |=> cnt32 == 32'h0) // R17
        else $error("pair did not clear on match");
    chk_wide_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wide_match |=> stat_ff[ptmr_pkg::IRQ_ODD]) // R2
        else $error("pair match not on odd flag");
    chk_wide_even_quiet: assert property (@(posedge hclk)
        disable iff (!hresetn)
        wide && !w_clr && !$past(ev_event) && !stat_ff[0]
        |=> !stat_ff[0]) // R2
        else $error("even flag set in pair mode");
    chk_carry_high: assert property (@(posedge hclk) disable iff (!hresetn)
        wide && ev_tick && low_count_value_ff == 16'hFFFF && !match32
        && !w_lcnt && !w_hcnt
        |=> high_count_value_ff == $past(high_count_value_ff) + 16'h1) // R1
        else $error("carry into high word missing");
    chk_stop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !ev_run && !w_lcnt |=> $stable(low_count_value_ff)) // R4
        else $error("stopped timer counted");
    chk_idle_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        even_control_reg_ff[ptmr_pkg::BIT_IDLE] && device_idle
        |-> !ev_tick) // R5
        else $error("timer ran in idle");
    chk_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (even_control_reg_ff & ~ptmr_pkg::EVEN_MASK) == 16'h0
        && (odd_control_reg_ff & ~ptmr_pkg::ODD_MASK) == 16'h0) // R16
        else $error("unused control bit set");
    chk_adc_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        ~wide && match_hi |=> adc_trigger) // R12
        else $error("converter trigger missing");
    chk_gate_ext: assert property (@(posedge hclk) disable iff (!hresetn)
        even_control_reg_ff[ptmr_pkg::BIT_CSRC] && ev_run && !ev_stop
        && even_control_reg_ff[5:4] == 2'h0 && !even_ext_clock_pin
        |-> !ev_tick) // R6 R8
        else $error("tick without pin edge");

    // ==========================================================
    // Single timers, pair count, gating, trigger and interrupt
    // Even timer alone on the internal clock with the gate in use
    wire gate_cfg = ~wide & ev_run & ~ev_stop
        & even_control_reg_ff[ptmr_pkg::BIT_GATE]
        & ~even_control_reg_ff[ptmr_pkg::BIT_CSRC];
    sequence s_gate_high;
        gate_cfg && even_gate_pin;
    endsequence
    sequence s_gate_low;
        gate_cfg && !even_gate_pin;
    endsequence

    chk_single_wrap: assert property ( // R17
        !wide && match_lo && !w_lcnt |=> low_count_value_ff == 16'h0)
        else $error("even timer did not clear on match");

    chk_single_flag: assert property ( // R17
        !wide && match_lo |=> stat_ff[ptmr_pkg::IRQ_EVEN])
        else $error("even match flag missing");

    chk_odd_wrap: assert property ( // R17
        !wide && match_hi && !w_hcnt |=> high_count_value_ff == 16'h0)
        else $error("odd timer did not clear on match");

    chk_odd_flag: assert property ( // R17
        !wide && match_hi |=> stat_ff[ptmr_pkg::IRQ_ODD])
        else $error("odd match flag missing");

    chk_pair_count: assert property ( // R1
        wide && ev_tick && !match32 && !w_lcnt && !w_hcnt
        |=> cnt32 == $past(cnt32) + 32'h1)
        else $error("pair did not count up");

    chk_high_hold: assert property ( // R2
        wide && !ev_tick && !w_hcnt |=> $stable(high_count_value_ff))
        else $error("high word moved without pair tick");

    chk_count_write: assert property ( // R10
        w_lcnt |=> low_count_value_ff == $past(wd))
        else $error("count write lost");

    // Gated mode
    chk_gate_fall: assert property ( // R18
        s_gate_high ##1 s_gate_low |=> stat_ff[ptmr_pkg::IRQ_EVEN])
        else $error("gate fall did not set flag");

    chk_gate_block: assert property ( // R18
        gate_cfg && !even_gate_pin |-> !ev_tick)
        else $error("gated timer counted with gate low");

    // Trigger and interrupt line
    chk_adc_wide: assert property ( // R12
        wide && match32 |=> adc_trigger)
        else $error("pair trigger missing");

    chk_adc_quiet: assert property ( // R12
        !adc_evt |=> !adc_trigger)
        else $error("trigger without odd match");

    chk_irq_level: assert property ( // R17
        irq == |(stat_ff & en_ff))
        else $error("interrupt not level of enabled flags");
endmodule

// *** bench/pin_model.sv ***
// Purpose: far-side model driving the external clock pins of the timers
// Assumes: the block samples the pins on hclk and counts rising edges
// Notes: pins rest low between bursts, as a stopped clock source would
`timescale 1ns/1ps
module pin_model (
    // Clock
    input wire logic hclk,
    // Burst request: which pins, how many rising edges
    input wire logic [1:0] go,
    input wire logic [7:0] n_edges,
    // Pins and status
    output logic even_ext_clock_pin,
    output logic odd_ext_clock_pin,
    output logic busy
);
    logic [1:0] sel_ff = 2'h0;
    logic [9:0] phase_ff = 10'h000;

    // ========================================
    // Burst sequencer
    // Four hclk per pin period, so each level is seen by two samples
    always_ff @(posedge hclk) begin
        if (go != 2'h0) begin
            sel_ff <= go;
            phase_ff <= {n_edges, 2'h0};
        end else if (phase_ff != 10'h000) begin
            phase_ff <= phase_ff - 10'h001;
        end
    end

    // Pins high in the middle half of each period, low otherwise
    assign even_ext_clock_pin = sel_ff[0] & phase_ff[1];
    assign odd_ext_clock_pin = sel_ff[1] & phase_ff[1];
    assign busy = (phase_ff != 10'h000);
endmodule

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for the paired 16/32-bit timer
// Assumes: zero-wait AHB-Lite slave, pin model on the far side
// Notes: external edges come in exact bursts, so counts are exact
`timescale 1ns/1ps
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, busy;
    logic adc_trigger, device_idle, even_gate_pin, odd_gate_pin;
    logic even_ext_clock_pin, odd_ext_clock_pin;
    logic [1:0] htrans, pgo;
    logic [2:0] hsize;
    logic [7:0] haddr, pn;
    logic [31:0] hwdata, hrdata, rv;
    int miscompares = 0;
    int n_tests = 0;
    int adc_n = 0;

    // The one slave's ready is the bus ready
    assign hready = hreadyout;

    ptmr_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .device_idle(device_idle),
        .even_ext_clock_pin(even_ext_clock_pin),
        .odd_ext_clock_pin(odd_ext_clock_pin), .even_gate_pin(even_gate_pin),
        .odd_gate_pin(odd_gate_pin), .irq(irq), .adc_trigger(adc_trigger));

    pin_model i_pins (.hclk(hclk), .go(pgo), .n_edges(pn),
        .even_ext_clock_pin(even_ext_clock_pin),
        .odd_ext_clock_pin(odd_ext_clock_pin), .busy(busy));

    // ========================================
    // Clock and trigger pulse counter
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (adc_trigger === 1'b1) adc_n <= adc_n + 1;
    end

    // ========================================
    // Reporting
    task automatic end_of_test(input bit hung);
        if (hung) miscompares++;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, lo, hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    // ========================================
    // Bus master: hold each phase until ready is sampled high
    task automatic wait_rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            i++;
            if (i > 100) end_of_test(1'b1);
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rv = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] lo, hi);
        bus(a, 1'b0, 32'h0);
        chk(rv, lo, hi);
    endtask

    // Burst of rising edges on the chosen pins, then sync settling
    task automatic pulse(input logic [1:0] g, input logic [7:0] n);
        int i;
        pgo <= g;
        pn <= n;
        @(posedge hclk);
        pgo <= 2'h0;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (busy === 1'b1 && i < 1200);
        if (i >= 1200) end_of_test(1'b1);
        repeat (4) @(posedge hclk);
    endtask

    // ========================================
    // Scenarios
    task automatic t_regs;
        rc(ptmr_pkg::OFS_EVEN_CON, 32'h0, 32'h0);
        rc(ptmr_pkg::OFS_ODD_CON, 32'h0, 32'h0);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'hFFFF_FFFF);
        rc(ptmr_pkg::OFS_EVEN_CON, 32'hA07A, 32'hA07A);
        wr(ptmr_pkg::OFS_ODD_CON, 32'hFFFF_FFFF);
        rc(ptmr_pkg::OFS_ODD_CON, 32'hA072, 32'hA072);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h0);
        wr(ptmr_pkg::OFS_ODD_CON, 32'h0);
        rc(8'hF0, 32'h0, 32'h0);
        wr(ptmr_pkg::OFS_LOW_CNT, 32'h0);
        wr(ptmr_pkg::OFS_HIGH_CNT, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_single;
        int i, a;
        wr(ptmr_pkg::OFS_LOW_PER, 32'h3);
        wr(ptmr_pkg::OFS_IRQ_EN, 32'h1);
        a = adc_n;
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h8000);
        for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge hclk);
        chk({31'h0, irq}, 32'h1, 32'h1);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h0);
        rc(ptmr_pkg::OFS_LOW_CNT, 32'h0, 32'h3);
        rc(ptmr_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
        chk(32'(adc_n - a), 32'h0, 32'h0);
        wr(ptmr_pkg::OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0, 32'h0);
        rc(ptmr_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
        wr(ptmr_pkg::OFS_IRQ_CLR, 32'h1);
        rc(ptmr_pkg::OFS_IRQ_STAT, 32'h0, 32'h0);
        $display("test single done");
    endtask

    // Pair on external clock with gate bit set and gate low
    task automatic t_wide;
        int a;
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h0008);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h004A);
        wr(ptmr_pkg::OFS_LOW_CNT, 32'hFFFE);
        wr(ptmr_pkg::OFS_LOW_PER, 32'h2);
        wr(ptmr_pkg::OFS_HIGH_PER, 32'h1);
        wr(ptmr_pkg::OFS_IRQ_EN, 32'h2);
        a = adc_n;
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h804A);
        pulse(2'h1, 8'h3);
        rc(ptmr_pkg::OFS_LOW_CNT, 32'h1, 32'h1);
        rc(ptmr_pkg::OFS_HIGH_CNT, 32'h1, 32'h1);
        rc(ptmr_pkg::OFS_IRQ_STAT, 32'h0, 32'h0);
        pulse(2'h1, 8'h2);
        rc(ptmr_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1, 32'h1);
        chk(32'(adc_n - a), 32'h1, 32'h1);
        rc(ptmr_pkg::OFS_LOW_CNT, 32'h0, 32'h0);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h0);
        wr(ptmr_pkg::OFS_IRQ_CLR, 32'h3);
        wr(ptmr_pkg::OFS_IRQ_EN, 32'h0);
        $display("test wide done");
    endtask

    task automatic t_odd;
        int a;
        wr(ptmr_pkg::OFS_HIGH_CNT, 32'h0);
        wr(ptmr_pkg::OFS_HIGH_PER, 32'h4);
        a = adc_n;
        wr(ptmr_pkg::OFS_ODD_CON, 32'h8002);
        pulse(2'h2, 8'h3);
        rc(ptmr_pkg::OFS_HIGH_CNT, 32'h3, 32'h3);
        rc(ptmr_pkg::OFS_LOW_CNT, 32'h0, 32'h0);
        pulse(2'h2, 8'h2);
        rc(ptmr_pkg::OFS_HIGH_CNT, 32'h0, 32'h0);
        rc(ptmr_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
        chk(32'(adc_n - a), 32'h1, 32'h1);
        wr(ptmr_pkg::OFS_ODD_CON, 32'h0);
        wr(ptmr_pkg::OFS_IRQ_CLR, 32'h2);
        $display("test odd done");
    endtask

    // Run length is 1024 cycles plus the stop write
    task automatic t_prescale;
        int c, d;
        wr(ptmr_pkg::OFS_LOW_PER, 32'hFFFF);
        for (c = 0; c < 4; c++) begin
            d = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
            wr(ptmr_pkg::OFS_LOW_CNT, 32'h0);
            wr(ptmr_pkg::OFS_EVEN_CON, 32'(32'h8000 + c * 16));
            repeat (1024) @(posedge hclk);
            wr(ptmr_pkg::OFS_EVEN_CON, 32'h0);
            rc(ptmr_pkg::OFS_LOW_CNT, 32'(1024 / d), 32'(1024 / d + 4));
        end
        $display("test prescale done");
    endtask

    task automatic t_idle;
        logic [31:0] a;
        wr(ptmr_pkg::OFS_LOW_CNT, 32'h0);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'hA000);
        device_idle <= 1'b1;
        repeat (4) @(posedge hclk);
        rc(ptmr_pkg::OFS_LOW_CNT, 32'h0, 32'hFFFF);
        a = rv;
        repeat (20) @(posedge hclk);
        rc(ptmr_pkg::OFS_LOW_CNT, a, a);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h8000);
        repeat (20) @(posedge hclk);
        rc(ptmr_pkg::OFS_LOW_CNT, a + 32'd20, a + 32'd30);
        device_idle <= 1'b0;
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h0);
        $display("test idle done");
    endtask

    task automatic t_gate;
        wr(ptmr_pkg::OFS_LOW_CNT, 32'h0);
        wr(ptmr_pkg::OFS_IRQ_EN, 32'h1);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h8040);
        repeat (10) @(posedge hclk);
        rc(ptmr_pkg::OFS_LOW_CNT, 32'h0, 32'h0);
        even_gate_pin <= 1'b1;
        repeat (20) @(posedge hclk);
        even_gate_pin <= 1'b0;
        repeat (5) @(posedge hclk);
        rc(ptmr_pkg::OFS_LOW_CNT, 32'd18, 32'd22);
        rc(ptmr_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h1, 32'h1);
        wr(ptmr_pkg::OFS_EVEN_CON, 32'h0);
        wr(ptmr_pkg::OFS_IRQ_CLR, 32'h1);
        $display("test gate done");
    endtask

    // ========================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        device_idle = 1'b0;
        even_gate_pin = 1'b0;
        odd_gate_pin = 1'b0;
        pgo = 2'h0;
        pn = 8'h00;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_single();
        t_wide();
        t_odd();
        t_prescale();
        t_idle();
        t_gate();
        end_of_test(1'b0);
    end
endmodule
